// File: hdl/nfc_map.svh
// Constants of the NAND flash host controller: command codes, address and geometry, timing.
// Included by the package and by the controller files.
`ifndef NFC_MAP_SVH
`define NFC_MAP_SVH
`define NFC_CMD_READ1 8'h00
`define NFC_CMD_READ2 8'h30
`define NFC_CMD_CPBK_RD2 8'h35
`define NFC_CMD_READ_ID 8'h90
`define NFC_CMD_RESET 8'hff
`define NFC_CMD_PROG1 8'h80
`define NFC_CMD_PROG2 8'h10
`define NFC_CMD_CACHE2 8'h15
`define NFC_CMD_CPBK_PG1 8'h85
`define NFC_CMD_ERASE1 8'h60
`define NFC_CMD_ERASE2 8'hd0
`define NFC_CMD_RND_OUT1 8'h05
`define NFC_CMD_RND_OUT2 8'he0
`define NFC_CMD_STATUS 8'h70
`define NFC_COL_BITS 12
`define NFC_ROW_BITS 16
`define NFC_PAGES_PER_BLOCK 64
`define NFC_BLOCKS 1024
`define NFC_SPARE_X8 12'h800
`define NFC_SPARE_X16 12'h400
// Strobe low and high phases in ns; cycle counts at 4 ns, rounded up
`define NFC_CLK_NS 4
`define NFC_T_LOW_NS 60
`define NFC_T_HIGH_NS 20
`define NFC_T_LOW_CYC ((`NFC_T_LOW_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_T_HIGH_CYC ((`NFC_T_HIGH_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`endif

// File: hdl/nfc_pkg.sv
// Types of the NAND flash host controller.
// Assumes nfc_map.svh is on the include path.
`include "nfc_map.svh"
package nfc_pkg;
  // Operations the user may request
  typedef enum logic [3:0] {
    NFC_OP_READ = 4'h0,
    NFC_OP_PROG = 4'h1,
    NFC_OP_CACHE_PROG = 4'h2,
    NFC_OP_ERASE = 4'h3,
    NFC_OP_RESET = 4'h4,
    NFC_OP_STATUS = 4'h5,
    NFC_OP_READ_ID = 4'h6,
    NFC_OP_CPBK_READ = 4'h7,
    NFC_OP_CPBK_PROG = 4'h8,
    NFC_OP_RND_IN = 4'h9,
    NFC_OP_RND_OUT = 4'ha,
    NFC_OP_AUTO_READ = 4'hb
  } nfc_op_t;

  typedef struct packed {
    nfc_op_t op;
    logic [`NFC_COL_BITS-1:0] col;
    logic [`NFC_ROW_BITS-1:0] row;
    logic [15:0] count;
  } nfc_req_t;

  // Pin side of the flash
  typedef struct packed {
    logic chip_sel_n;
    logic cmd_latch;
    logic addr_latch;
    logic write_strobe_n;
    logic read_strobe_n;
    logic write_guard_n;
  } nfc_pins_t;

  // One strobe cycle handed to the strobe engine
  typedef enum logic [1:0] {
    NFC_CYC_CMD = 2'b00,
    NFC_CYC_ADDR = 2'b01,
    NFC_CYC_WDATA = 2'b10,
    NFC_CYC_RDATA = 2'b11
  } nfc_cyc_t;
endpackage : nfc_pkg

// File: hdl/nfc_strobe.sv
// One bus cycle on the flash pins: command, address, write data or read data.
// Assumes a 250 MHz ref_clk; io input is already synchronised by the caller.
`include "nfc_map.svh"
module nfc_strobe #(
  parameter int IO_W = 8,
  parameter int LOW_CYC = `NFC_T_LOW_CYC,
  parameter int HIGH_CYC = `NFC_T_HIGH_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Cycle request
  input wire logic go,
  input wire nfc_pkg::nfc_cyc_t kind,
  input wire logic [IO_W-1:0] wdata,
  output logic done,
  output logic [IO_W-1:0] rdata,
  // Pins
  output logic cmd_latch,
  output logic addr_latch,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic [IO_W-1:0] io_out,
  output logic io_oe_n,
  input wire logic [IO_W-1:0] io_in
);
  initial begin
    if (LOW_CYC < 1 || HIGH_CYC < 1 || LOW_CYC > 255 || HIGH_CYC > 255) begin
      $error("nfc_strobe: phase counts out of range");
    end
  end

  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_LOW = 2'b01, ST_HIGH = 2'b10} st_t;
  typedef struct packed {
    st_t st;
    logic [7:0] cnt;
    nfc_pkg::nfc_cyc_t kind;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic [IO_W-1:0] dout;
    logic oe_n;
    logic [IO_W-1:0] din;
    logic done;
  } s_t;
  s_t s_reg, s_next;

  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    unique case (s_reg.st)
      ST_IDLE: begin
        if (go) begin
          s_next.st = ST_LOW;
          s_next.cnt = LOW_CYC[7:0];
          s_next.kind = kind;
          s_next.cle = (kind == nfc_pkg::NFC_CYC_CMD);
          s_next.ale = (kind == nfc_pkg::NFC_CYC_ADDR);
          s_next.dout = wdata;
          s_next.oe_n = (kind == nfc_pkg::NFC_CYC_RDATA);
          s_next.we_n = (kind == nfc_pkg::NFC_CYC_RDATA);
          s_next.re_n = (kind != nfc_pkg::NFC_CYC_RDATA);
        end
      end
      ST_LOW: begin
        s_next.cnt = s_reg.cnt - 8'h01;
        if (s_reg.cnt == 8'h01) begin
          // Sample read data just before the read strobe rises
          if (s_reg.kind == nfc_pkg::NFC_CYC_RDATA) s_next.din = io_in;
          s_next.we_n = 1'b1;
          s_next.re_n = 1'b1;
          s_next.st = ST_HIGH;
          s_next.cnt = HIGH_CYC[7:0];
        end
      end
      ST_HIGH: begin
        s_next.cnt = s_reg.cnt - 8'h01;
        if (s_reg.cnt == 8'h01) begin
          s_next.st = ST_IDLE;
          s_next.cle = 1'b0;
          s_next.ale = 1'b0;
          s_next.oe_n = 1'b1;
          s_next.done = 1'b1;
        end
      end
      default: s_next.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_reg <= '{st: ST_IDLE, cnt: 8'h00, kind: nfc_pkg::NFC_CYC_CMD, cle: 1'b0, ale: 1'b0,
                 we_n: 1'b1, re_n: 1'b1, dout: '0, oe_n: 1'b1, din: '0, done: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign done = s_reg.done;
  assign rdata = s_reg.din;
  assign cmd_latch = s_reg.cle;
  assign addr_latch = s_reg.ale;
  assign write_strobe_n = s_reg.we_n;
  assign read_strobe_n = s_reg.re_n;
  assign io_out = s_reg.dout;
  assign io_oe_n = s_reg.oe_n;
endmodule : nfc_strobe

// File: hdl/nfc_host.sv
// Host controller for a NAND flash: sequences command, address and data cycles.
// Assumes one flash on the pins; ready/busy is open drain with a pull-up outside.
`include "nfc_map.svh"
module nfc_host #(
  parameter int IO_W = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // User request
  input wire logic req_valid,
  output logic req_ready,
  input wire nfc_pkg::nfc_req_t req,
  input wire logic protect,
  // Write data stream
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [IO_W-1:0] wr_data,
  // Read data stream
  output logic rd_valid,
  output logic [IO_W-1:0] rd_data,
  output logic op_done,
  // Flash pins
  output nfc_pkg::nfc_pins_t pins,
  output logic [IO_W-1:0] io_out,
  output logic io_oe_n,
  input wire logic [IO_W-1:0] io_in,
  input wire logic ready_busy_n,
  input wire logic auto_read_sel
);
  initial begin
    if (IO_W != 8 && IO_W != 16) $error("nfc_host: IO_W must be 8 or 16");
  end

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_CMD1 = 3'b001,
    PH_ADDR = 3'b010,
    PH_DATA = 3'b011,
    PH_CMD2 = 3'b100,
    PH_WAIT = 3'b101,
    PH_DONE = 3'b110
  } ph_t;

  typedef struct packed {
    ph_t ph;
    nfc_pkg::nfc_req_t r;
    logic [2:0] acnt;
    logic [15:0] dcnt;
    logic busy_wait;
    logic cs_n;
    logic rd_v;
    logic [IO_W-1:0] rd_d;
    logic done;
    logic [2:0] rb_sync;
    logic rb_ok;
  } s_t;
  s_t s_reg, s_next;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode helpers

  function automatic logic [7:0] first_cmd(input nfc_pkg::nfc_op_t op);
    unique case (op)
      nfc_pkg::NFC_OP_READ, nfc_pkg::NFC_OP_CPBK_READ: first_cmd = `NFC_CMD_READ1;
      nfc_pkg::NFC_OP_PROG, nfc_pkg::NFC_OP_CACHE_PROG: first_cmd = `NFC_CMD_PROG1;
      nfc_pkg::NFC_OP_CPBK_PROG, nfc_pkg::NFC_OP_RND_IN: first_cmd = `NFC_CMD_CPBK_PG1;
      nfc_pkg::NFC_OP_ERASE: first_cmd = `NFC_CMD_ERASE1;
      nfc_pkg::NFC_OP_RESET: first_cmd = `NFC_CMD_RESET;
      nfc_pkg::NFC_OP_STATUS: first_cmd = `NFC_CMD_STATUS;
      nfc_pkg::NFC_OP_READ_ID: first_cmd = `NFC_CMD_READ_ID;
      nfc_pkg::NFC_OP_RND_OUT: first_cmd = `NFC_CMD_RND_OUT1;
      default: first_cmd = `NFC_CMD_STATUS;
    endcase
  endfunction : first_cmd

  function automatic logic [7:0] second_cmd(input nfc_pkg::nfc_op_t op);
    unique case (op)
      nfc_pkg::NFC_OP_READ: second_cmd = `NFC_CMD_READ2;
      nfc_pkg::NFC_OP_CPBK_READ: second_cmd = `NFC_CMD_CPBK_RD2;
      nfc_pkg::NFC_OP_PROG, nfc_pkg::NFC_OP_CPBK_PROG: second_cmd = `NFC_CMD_PROG2;
      nfc_pkg::NFC_OP_CACHE_PROG: second_cmd = `NFC_CMD_CACHE2;
      nfc_pkg::NFC_OP_ERASE: second_cmd = `NFC_CMD_ERASE2;
      nfc_pkg::NFC_OP_RND_OUT: second_cmd = `NFC_CMD_RND_OUT2;
      default: second_cmd = 8'h00;
    endcase
  endfunction : second_cmd

  // Address cycles per operation; random moves send only the column
  function automatic logic [2:0] addr_cycles(input nfc_pkg::nfc_op_t op);
    unique case (op)
      nfc_pkg::NFC_OP_READ, nfc_pkg::NFC_OP_CPBK_READ, nfc_pkg::NFC_OP_PROG,
      nfc_pkg::NFC_OP_CACHE_PROG, nfc_pkg::NFC_OP_CPBK_PROG: addr_cycles = 3'd4;
      nfc_pkg::NFC_OP_ERASE: addr_cycles = 3'd2;
      nfc_pkg::NFC_OP_RND_IN, nfc_pkg::NFC_OP_RND_OUT: addr_cycles = 3'd2;
      nfc_pkg::NFC_OP_READ_ID: addr_cycles = 3'd1;
      default: addr_cycles = 3'd0;
    endcase
  endfunction : addr_cycles

  function automatic logic has_second(input nfc_pkg::nfc_op_t op);
    has_second = (second_cmd(op) != 8'h00);
  endfunction : has_second

  function automatic logic writes_data(input nfc_pkg::nfc_op_t op);
    writes_data = (op == nfc_pkg::NFC_OP_PROG) || (op == nfc_pkg::NFC_OP_CACHE_PROG) ||
                  (op == nfc_pkg::NFC_OP_RND_IN);
  endfunction : writes_data

  // Ops whose execute byte makes the flash go busy
  function automatic logic waits_ready(input nfc_pkg::nfc_op_t op);
    waits_ready = (op == nfc_pkg::NFC_OP_READ) || (op == nfc_pkg::NFC_OP_CPBK_READ) ||
                  (op == nfc_pkg::NFC_OP_PROG) || (op == nfc_pkg::NFC_OP_CACHE_PROG) ||
                  (op == nfc_pkg::NFC_OP_CPBK_PROG) || (op == nfc_pkg::NFC_OP_ERASE) ||
                  (op == nfc_pkg::NFC_OP_RESET);
  endfunction : waits_ready

  // Address byte n; x8 and x16 split column and row differently
  function automatic logic [7:0] addr_byte(input nfc_pkg::nfc_req_t r, input logic [2:0] n);
    logic [27:0] a;
    a = '0;
    if (IO_W == 8) a = {r.row, r.col};
    else a = {1'b0, r.row, r.col[10:0]};
    if (r.op == nfc_pkg::NFC_OP_ERASE) n = n + 3'd2;
    unique case (n)
      3'd0: addr_byte = a[7:0];
      3'd1: addr_byte = (IO_W == 8) ? {4'h0, a[11:8]} : {5'h00, a[10:8]};
      3'd2: addr_byte = (IO_W == 8) ? a[19:12] : a[18:11];
      3'd3: addr_byte = (IO_W == 8) ? a[27:20] : a[26:19];
      default: addr_byte = 8'h00;
    endcase
  endfunction : addr_byte

  ////////////////////////////////////////////////////////////////////////////
  // Strobe engine

  logic st_go, st_done;
  nfc_pkg::nfc_cyc_t st_kind;
  logic [IO_W-1:0] st_wdata, st_rdata;
  logic cle_w, ale_w, we_w, re_w;

  nfc_strobe #(.IO_W(IO_W)) u_strobe (
    .ref_clk(ref_clk),
    .reset(reset),
    .go(st_go),
    .kind(st_kind),
    .wdata(st_wdata),
    .done(st_done),
    .rdata(st_rdata),
    .cmd_latch(cle_w),
    .addr_latch(ale_w),
    .write_strobe_n(we_w),
    .read_strobe_n(re_w),
    .io_out(io_out),
    .io_oe_n(io_oe_n),
    .io_in(io_in)
  );

  logic pending;
  logic stream_in, stream_out;
  assign stream_in = writes_data(s_reg.r.op);
  assign stream_out = (s_reg.r.op == nfc_pkg::NFC_OP_READ) ||
                      (s_reg.r.op == nfc_pkg::NFC_OP_RND_OUT) ||
                      (s_reg.r.op == nfc_pkg::NFC_OP_STATUS) ||
                      (s_reg.r.op == nfc_pkg::NFC_OP_READ_ID) ||
                      (s_reg.r.op == nfc_pkg::NFC_OP_AUTO_READ);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.rd_v = 1'b0;
    st_go = 1'b0;
    st_kind = nfc_pkg::NFC_CYC_CMD;
    st_wdata = '0;
    pending = 1'b0;
    // Three-stage sync of the ready/busy pin; change taken when stages 2 and 3 agree
    s_next.rb_sync = {s_reg.rb_sync[1:0], ready_busy_n};
    if (s_reg.rb_sync[2] == s_reg.rb_sync[1]) s_next.rb_ok = s_reg.rb_sync[2];
    unique case (s_reg.ph)
      PH_IDLE: begin
        // Reset and status may go while busy; anything else waits for ready
        if (req_valid && (s_reg.rb_ok || req.op == nfc_pkg::NFC_OP_RESET ||
            req.op == nfc_pkg::NFC_OP_STATUS)) begin
          s_next.r = req;
          s_next.acnt = 3'd0;
          s_next.busy_wait = 1'b0;
          s_next.dcnt = req.count;
          s_next.cs_n = 1'b0;
          s_next.ph = (req.op == nfc_pkg::NFC_OP_AUTO_READ) ? PH_DATA : PH_CMD1;
        end
      end
      PH_CMD1: begin
        pending = 1'b1;
        st_kind = nfc_pkg::NFC_CYC_CMD;
        st_wdata = IO_W'(first_cmd(s_reg.r.op));
        if (st_done) begin
          s_next.ph = (addr_cycles(s_reg.r.op) != 3'd0) ? PH_ADDR :
                      (s_reg.r.op == nfc_pkg::NFC_OP_RESET) ? PH_WAIT : PH_DATA;
        end
      end
      PH_ADDR: begin
        pending = 1'b1;
        st_kind = nfc_pkg::NFC_CYC_ADDR;
        st_wdata = IO_W'(addr_byte(s_reg.r, s_reg.acnt));
        if (st_done) begin
          s_next.acnt = s_reg.acnt + 3'd1;
          // No surplus address cycles are sent
          if (s_reg.acnt + 3'd1 == addr_cycles(s_reg.r.op)) begin
            if (writes_data(s_reg.r.op)) s_next.ph = PH_DATA;
            else if (has_second(s_reg.r.op)) s_next.ph = PH_CMD2;
            else s_next.ph = PH_DATA;
          end
        end
      end
      PH_DATA: begin
        pending = 1'b1;
        st_kind = stream_in ? nfc_pkg::NFC_CYC_WDATA : nfc_pkg::NFC_CYC_RDATA;
        st_wdata = wr_data;
        if (s_reg.dcnt == 16'h0000) begin
          pending = 1'b0;
          s_next.ph = (has_second(s_reg.r.op) && stream_in) ? PH_CMD2 : PH_DONE;
        end
        if (st_done) begin
          s_next.dcnt = s_reg.dcnt - 16'h0001;
          s_next.rd_v = stream_out;
          s_next.rd_d = st_rdata;
        end
      end
      PH_CMD2: begin
        pending = 1'b1;
        st_kind = nfc_pkg::NFC_CYC_CMD;
        st_wdata = IO_W'(second_cmd(s_reg.r.op));
        if (st_done) begin
          s_next.busy_wait = 1'b0;
          if (waits_ready(s_reg.r.op)) s_next.ph = PH_WAIT;
          else s_next.ph = PH_DATA;
        end
      end
      PH_WAIT: begin
        // Wait to see busy then ready; chip select stays low meanwhile
        if (!s_reg.rb_ok) s_next.busy_wait = 1'b1;
        if (s_reg.busy_wait && s_reg.rb_ok) begin
          s_next.ph = stream_out ? PH_DATA : PH_DONE;
        end
      end
      PH_DONE: begin
        s_next.cs_n = 1'b1;
        s_next.done = 1'b1;
        s_next.ph = PH_IDLE;
      end
      default: s_next.ph = PH_IDLE;
    endcase
    // Only the first go of a cycle counts; engine is idle between cycles
    st_go = pending && io_oe_n && !st_done && we_w && re_w && !cle_w && !ale_w &&
            (st_kind != nfc_pkg::NFC_CYC_WDATA || wr_valid);
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_reg <= '{ph: PH_IDLE, r: '0, acnt: 3'd0, dcnt: 16'h0000, busy_wait: 1'b0,
                 cs_n: 1'b1, rd_v: 1'b0, rd_d: '0, done: 1'b0, rb_sync: 3'b000,
                 rb_ok: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  // A write byte is consumed when its strobe cycle starts
  assign wr_ready = st_go && (st_kind == nfc_pkg::NFC_CYC_WDATA);
  assign req_ready = (s_reg.ph == PH_IDLE) && (s_reg.rb_ok ||
                     req.op == nfc_pkg::NFC_OP_RESET || req.op == nfc_pkg::NFC_OP_STATUS);
  assign rd_valid = s_reg.rd_v;
  assign rd_data = s_reg.rd_d;
  assign op_done = s_reg.done;
  assign pins.chip_sel_n = s_reg.cs_n;
  assign pins.cmd_latch = cle_w;
  assign pins.addr_latch = ale_w;
  assign pins.write_strobe_n = we_w;
  assign pins.read_strobe_n = re_w;
  assign pins.write_guard_n = ~protect;
endmodule : nfc_host

// File: verification/nfc_host_props.sv
// Concurrent checks on the pins and user ports of the NAND flash host controller.
// Assumes a single ref_clk domain and the shared constants header on the include path.
`include "nfc_map.svh"
module nfc_host_props #(
  parameter int IO_W = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // User side
  input wire logic req_valid,
  input wire logic req_ready,
  input wire nfc_pkg::nfc_req_t req,
  input wire logic protect,
  input wire logic rd_valid,
  input wire logic op_done,
  // Flash side
  input wire nfc_pkg::nfc_pins_t pins,
  input wire logic [IO_W-1:0] io_out,
  input wire logic io_oe_n,
  input wire logic ready_busy_n
);
  localparam int LOW_CYC = `NFC_T_LOW_CYC;
  typedef struct packed {
    logic we;
    logic [7:0] low;
    logic [1:0] ac;
    logic armed;
    logic erase;
  } nfc_chk_t;
  nfc_chk_t st_reg;
  nfc_chk_t st_next;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  ////////////////////////////////////////
  // Armed from an execute byte until busy is seen, so early traffic shows
  always_comb begin
    st_next = st_reg;
    st_next.we = pins.write_strobe_n;
    st_next.low = pins.write_strobe_n ? 8'h00 : st_reg.low + 8'h01;
    if (pins.write_strobe_n && !st_reg.we) begin
      if (pins.cmd_latch) begin
        st_next.ac = 2'h0;
        st_next.erase = io_out[7:0] == 8'h60;
        st_next.armed = io_out[7:0] inside {8'h30, 8'h35, 8'h10, 8'h15, 8'hd0, 8'hff};
      end else if (pins.addr_latch && st_reg.ac != 2'h3) begin
        st_next.ac = st_reg.ac + 2'h1;
      end
    end
    if (!ready_busy_n) begin
      st_next.armed = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_reg <= '{we: 1'b1, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////
  AST_GUARD: assert property (pins.write_guard_n == !protect)
    else $error("write guard does not follow protect");
  AST_WE_CS: assert property ($fell(pins.write_strobe_n) |-> !pins.chip_sel_n)
    else $error("write strobe fell with chip deselected");
  AST_WE_LOW: assert property ($rose(pins.write_strobe_n) |-> st_reg.low >= 8'(LOW_CYC))
    else $error("write strobe low phase too short");
  AST_WE_HOLD: assert property (!pins.write_strobe_n && !$past(pins.write_strobe_n)
    |-> $stable({pins.cmd_latch, pins.addr_latch, io_out}))
    else $error("latch select or byte moved during strobe");
  AST_WE_DRIVE: assert property ($rose(pins.write_strobe_n) |-> !$past(io_oe_n))
    else $error("bus not driven at write strobe rise");
  AST_LATCH: assert property (!(pins.cmd_latch && pins.addr_latch))
    else $error("command and address latch both high");
  AST_ADDR2: assert property ($rose(pins.write_strobe_n) && pins.addr_latch
    && st_reg.ac == 2'h1 && !st_reg.erase |-> io_out[7:4] == 4'h0)
    else $error("second column byte has upper lines set");
  AST_BUSY: assert property ((!ready_busy_n) [*5] ##0 req_ready
    |-> req.op inside {nfc_pkg::NFC_OP_RESET, nfc_pkg::NFC_OP_STATUS})
    else $error("request accepted while flash busy");
  AST_WAIT: assert property ($fell(pins.write_strobe_n) |-> !st_reg.armed)
    else $error("new byte before busy seen");
  AST_DONE: assert property (op_done |-> !st_reg.armed)
    else $error("operation done before busy seen");
  AST_RD: assert property (rd_valid |-> !$past(pins.read_strobe_n, 7))
    else $error("read word without read strobe");
  AST_RD_BUS: assert property (!pins.read_strobe_n
    |-> io_oe_n && !pins.chip_sel_n && pins.write_strobe_n)
    else $error("read strobe while bus driven or deselected");

  COV_ERASE: cover property ($rose(pins.write_strobe_n) && pins.cmd_latch && io_out[7:0] == 8'hd0);
  COV_REFUSE: cover property (req_valid && !req_ready && !ready_busy_n);
  COV_READ: cover property (rd_valid ##1 !rd_valid);
endmodule : nfc_host_props

bind nfc_host nfc_host_props #(.IO_W(IO_W)) nfc_host_props_i (
  .ref_clk(ref_clk),
  .reset(reset),
  .req_valid(req_valid),
  .req_ready(req_ready),
  .req(req),
  .protect(protect),
  .rd_valid(rd_valid),
  .op_done(op_done),
  .pins(pins),
  .io_out(io_out),
  .io_oe_n(io_oe_n),
  .ready_busy_n(ready_busy_n)
);

// File: verification/nfc_flash_model.sv
// Behavioural x8 NAND flash: command set, page register, busy line, auto read.
// Assumes a pull-up on the busy net and a bus resolved outside from the host's enable; io_q is always driven.
module nfc_flash_model #(
  parameter int BUSY_NS = 400,
  parameter logic [7:0] ID0 = 8'h3c, // Arbitrary value
  parameter logic [7:0] ID1 = 8'hc3, // Arbitrary value
  parameter logic [7:0] STAT_RDY = 8'h40
) (
  // Strobes and bus
  input wire nfc_pkg::nfc_pins_t pins,
  input wire logic [7:0] io,
  output logic [7:0] io_q = 8'h00,
  // Strap and status
  input wire logic auto_read_sel,
  output wire rb_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [int];
  logic [7:0] page [int];
  logic busy_q = 1'b0;
  int ac = 0;
  int col = 0;
  int row = 0;
  int mode = 0;

  assign rb_n = busy_q ? 1'b0 : 1'bz;

  ////////////////////////////////////////
  // Busy ends on its own; chip select is not consulted
  task automatic go_busy();
    busy_q = 1'b1;
    busy_q <= #(BUSY_NS) 1'b0;
  endtask : go_busy

  task automatic load();
    page.delete();
    foreach (mem[k]) if (k / 4096 == row) page[k % 4096] = mem[k];
  endtask : load

  task automatic do_cmd(input logic [7:0] c);
    if (busy_q && c != 8'hff && c != 8'h70) return;
    mode = 0;
    case (c)
      8'h00, 8'h85, 8'h05, 8'h90: ac = 0;
      8'h80: begin
        ac = 0;
        page.delete();
      end
      8'h60: ac = 2;
      8'h30, 8'h35: begin
        load();
        go_busy();
      end
      8'h10, 8'h15: begin
        if (pins.write_guard_n) foreach (page[i]) mem[row * 4096 + i] = page[i];
        go_busy();
      end
      8'hd0: begin
        if (pins.write_guard_n) foreach (mem[k]) if (k / 262144 == row / 64) mem[k] = 8'hff;
        go_busy();
      end
      8'h70: mode = 1;
      8'hff: go_busy();
      default: ;
    endcase
    if (c == 8'h90) begin
      mode = 2;
      col = 0;
    end
  endtask : do_cmd

  task automatic do_addr(input logic [7:0] a);
    case (ac)
      0: col[7:0] = a;
      1: col[11:8] = a[3:0];
      2: row[7:0] = a;
      3: row[15:8] = a;
      default: ;
    endcase
    ac++;
  endtask : do_addr

  ////////////////////////////////////////
  initial begin
    for (int i = 0; i < 8; i++) mem[i] = 8'h5a + 8'(i);
    #1;
    if (auto_read_sel === 1'b1) load();
  end

  always @(posedge pins.write_strobe_n) begin
    if (pins.chip_sel_n === 1'b0) begin
      if (pins.cmd_latch) do_cmd(io);
      else if (pins.addr_latch) do_addr(io);
      else begin
        page[col] = io;
        col++;
      end
    end
  end

  always @(negedge pins.read_strobe_n) begin
    if (pins.chip_sel_n === 1'b0) begin
      case (mode)
        1: io_q = STAT_RDY;
        2: io_q = col[0] ? ID1 : ID0;
        default: io_q = page.exists(col) ? page[col] : 8'hff;
      endcase
      col++;
    end
  end

  // Released bus must not look like a held byte
  always @(posedge pins.read_strobe_n) io_q = ~io_q;
endmodule : nfc_flash_model

// File: verification/testbench.sv
// Self-checking bench of the NAND flash host controller against a flash model.
// Assumes 250 MHz ref_clk; busy net pulled up, bench may also hold it low.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] ID0 = 8'h3c; // Arbitrary value
  localparam logic [7:0] ID1 = 8'hc3; // Arbitrary value
  localparam logic [7:0] STAT = 8'h40;
  logic ref_clk;
  logic reset;
  logic req_valid;
  logic req_ready;
  nfc_pkg::nfc_req_t req;
  logic protect;
  logic wr_valid;
  logic wr_ready;
  logic [7:0] wr_data;
  logic rd_valid;
  logic [7:0] rd_data;
  logic op_done;
  nfc_pkg::nfc_pins_t pins;
  logic [7:0] io_out;
  logic io_oe_n;
  logic [7:0] flash_q;
  logic hold_busy;
  wire [7:0] io_in;
  tri1 rb_line;
  logic [7:0] wq [$];
  logic [7:0] rq [$];
  int num_errors = 0;
  int total_checks = 0;

  assign io_in = io_oe_n ? flash_q : io_out;
  assign rb_line = hold_busy ? 1'b0 : 1'bz;

  nfc_host #(.IO_W(8)) nfc_host_i (
    .ref_clk(ref_clk), .reset(reset), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .protect(protect), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data), .op_done(op_done),
    .pins(pins), .io_out(io_out), .io_oe_n(io_oe_n), .io_in(io_in),
    .ready_busy_n(rb_line), .auto_read_sel(1'b1)
  );

  nfc_flash_model #(.ID0(ID0), .ID1(ID1), .STAT_RDY(STAT)) nfc_flash_model_i (
    .pins(pins), .io(io_in), .io_q(flash_q), .auto_read_sel(1'b1), .rb_n(rb_line)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_rd(input string w, input logic [7:0] e [$]);
    chk({w, " count"}, 8'(e.size()), 8'(rq.size()));
    foreach (e[i]) chk(w, e[i], (i < rq.size()) ? rq[i] : 8'hxx);
  endtask : chk_rd

  task automatic run_op(input nfc_pkg::nfc_op_t op, input logic [11:0] c,
                        input logic [15:0] r, input int n);
    int k;
    rq.delete();
    @(posedge ref_clk);
    req <= '{op, c, r, 16'(n)};
    req_valid <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (req_ready !== 1'b1 && k < 4000);
    req_valid <= 1'b0;
    wr_valid <= wq.size() > 0;
    if (wq.size() > 0) wr_data <= wq[0];
    while (op_done !== 1'b1 && k < 12000) begin
      @(posedge ref_clk);
      if (rd_valid === 1'b1) rq.push_back(rd_data);
      if (wr_ready === 1'b1 && wq.size() > 0) void'(wq.pop_front());
      wr_valid <= wq.size() > 0;
      if (wq.size() > 0) wr_data <= wq[0];
      k++;
    end
    if (k >= 12000) begin
      num_errors++;
      $display("CHECK FAILED op wait expected done seen timeout");
      test_done();
    end
  endtask : run_op

  ////////////////////////////////////////
  task automatic t_flow();
    run_op(nfc_pkg::NFC_OP_AUTO_READ, 12'h000, 16'h0000, 4);
    chk_rd("auto read", {8'h5a, 8'h5b, 8'h5c, 8'h5d});
    wq = {8'h11, 8'h22, 8'h33, 8'h44};
    run_op(nfc_pkg::NFC_OP_PROG, 12'h803, 16'h0045, 4);
    run_op(nfc_pkg::NFC_OP_READ, 12'h802, 16'h0045, 5);
    chk_rd("spare read", {8'hff, 8'h11, 8'h22, 8'h33, 8'h44});
    protect <= 1'b1;
    wq = {8'ha5};
    run_op(nfc_pkg::NFC_OP_PROG, 12'h000, 16'h0046, 1);
    protect <= 1'b0;
    run_op(nfc_pkg::NFC_OP_READ, 12'h000, 16'h0046, 1);
    chk_rd("guarded page", {8'hff});
    $display("done: program and read");
  endtask : t_flow

  task automatic t_erase();
    run_op(nfc_pkg::NFC_OP_ERASE, 12'h000, 16'h0047, 0);
    run_op(nfc_pkg::NFC_OP_READ, 12'h803, 16'h0045, 1);
    chk_rd("erased page", {8'hff});
    run_op(nfc_pkg::NFC_OP_READ, 12'h000, 16'h0000, 1);
    chk_rd("other block", {8'h5a});
    $display("done: erase");
  endtask : t_erase

  task automatic t_copy();
    wq = {8'h01, 8'h02};
    run_op(nfc_pkg::NFC_OP_CACHE_PROG, 12'h000, 16'h0100, 2);
    run_op(nfc_pkg::NFC_OP_CPBK_READ, 12'h000, 16'h0100, 0);
    wq = {8'h77};
    run_op(nfc_pkg::NFC_OP_RND_IN, 12'h001, 16'h0100, 1);
    run_op(nfc_pkg::NFC_OP_CPBK_PROG, 12'h000, 16'h0200, 0);
    run_op(nfc_pkg::NFC_OP_READ, 12'h000, 16'h0200, 2);
    chk_rd("copied page", {8'h01, 8'h77});
    run_op(nfc_pkg::NFC_OP_RND_OUT, 12'h000, 16'h0200, 1);
    chk_rd("random out", {8'h01});
    $display("done: copy-back");
  endtask : t_copy

  task automatic t_cmds();
    run_op(nfc_pkg::NFC_OP_READ_ID, 12'h000, 16'h0000, 2);
    chk_rd("ident", {ID0, ID1});
    run_op(nfc_pkg::NFC_OP_RESET, 12'h000, 16'h0000, 0);
    hold_busy <= 1'b1;
    repeat (8) @(posedge ref_clk);
    req <= '{nfc_pkg::NFC_OP_READ, 12'h000, 16'h0000, 16'h0001};
    req_valid <= 1'b1;
    repeat (4) begin
      @(posedge ref_clk);
      chk("ready while busy", 8'h00, {7'h00, req_ready});
    end
    run_op(nfc_pkg::NFC_OP_STATUS, 12'h000, 16'h0000, 1);
    chk_rd("status while busy", {STAT});
    hold_busy <= 1'b0;
    $display("done: single-cycle commands");
  endtask : t_cmds

  initial begin
    req_valid = 1'b0;
    req = '0;
    protect = 1'b0;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    hold_busy = 1'b0;
    reset = 1'b1;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (5) @(posedge ref_clk);
    t_flow();
    t_erase();
    t_copy();
    t_cmds();
    test_done();
  end
endmodule : testbench
